//--- design/sas_pkg.sv
// Package for the converter sequencer: register offsets, reset values, fields, types.
// Assumes an 8051-style special function register port with 8-bit address and data.
package sas_pkg;

    localparam logic [7:0] off_sample_time = 8'hb4;
    localparam logic [7:0] off_scan_ctrl   = 8'hb5;
    localparam logic [7:0] off_clk_ctrl    = 8'hb6;
    localparam logic [7:0] off_result_hi   = 8'hb9;
    localparam logic [7:0] off_result_lo   = 8'hba;
    localparam logic [7:0] off_timing_one  = 8'hbb;
    localparam logic [7:0] off_timing_two  = 8'hbc;
    localparam logic [7:0] off_pin_sel_one = 8'hd9;
    localparam logic [7:0] off_pin_sel_two = 8'hda;
    localparam logic [7:0] off_pin_sel_thr = 8'hdb;
    localparam logic [7:0] off_pin_sel_fou = 8'hdc;
    localparam logic [7:0] off_ana_switch  = 8'hfe;

    localparam logic [7:0] rst_zero       = 8'h00;
    localparam logic [7:0] rst_timing_two = 8'h02;
    localparam logic [7:0] rst_ana_switch = 8'h1f;

    // Field positions
    localparam int start_bit      = 0;
    localparam int chan_lsb       = 1;
    localparam int chan_msb       = 5;
    localparam int ana_switch_adc = 0;
    localparam logic [4:0] chan_internal = 5'h1a;

    // Sampling phase is (setting + 1) * 4 converter clocks
    localparam logic [9:0] sample_mult = 10'h004;
    localparam int result_bits = 12;

    // Reference clock 250 MHz; converter clock is 8, 6, 4 or 3 MHz
    localparam int ref_clk_mhz = 250;
    localparam logic [7:0] div_code0 = 8'((ref_clk_mhz / 8) / 2);
    localparam logic [7:0] div_code1 = 8'((ref_clk_mhz / 6) / 2);
    localparam logic [7:0] div_code2 = 8'((ref_clk_mhz / 4) / 2);
    localparam logic [7:0] div_code3 = 8'((ref_clk_mhz / 3) / 2);

    typedef enum logic [1:0] {
        st_idle   = 2'b00,
        st_sample = 2'b01,
        st_convert = 2'b10,
        st_done   = 2'b11
    } sas_state_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sas_req_type;

    typedef struct packed {
        logic       sample;
        logic [4:0] chan;
        logic [11:0] dac;
    } sas_ana_type;

endpackage : sas_pkg

//--- design/sas_sequencer.sv
// Converter sequencer: registers, clock divider, sampling timer and 12-bit search.
// Assumes a same-clock register port and an asynchronous comparator input.
module sas_sequencer
    import sas_pkg::*;
(
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    // Register port
    input  wire sas_pkg::sas_req_type req,
    output logic [7:0]                rdata,
    // Analog front end
    input  wire logic                 comp_in,
    output sas_pkg::sas_ana_type      ana,
    output logic                      adc_power_down,
    output logic [7:0]                timing_one_out,
    output logic [7:0]                timing_two_out,
    output logic [31:0]               pin_sel_out,
    // Interrupt flag request
    output logic                      conv_irq
);
    import sas_pkg::*;

    logic [7:0] sample_time_setting, scan_control, converter_clock_control;
    logic [7:0] sampling_timing_one, sampling_timing_two, analog_module_switch;
    logic [7:0] pin_sel [4];
    logic [11:0] result;
    logic [11:0] trial;
    logic [3:0]  bit_idx;
    logic [9:0]  sample_cnt;
    logic [7:0]  div_cnt;
    logic        adc_tick;
    logic        comp_s1, comp_s2, comp_s3, comp_val;
    sas_state_type state;

    // Register decode
    wire wr_spt  = req.wr && req.addr == off_sample_time;
    wire wr_scan = req.wr && req.addr == off_scan_ctrl;
    wire wr_clk  = req.wr && req.addr == off_clk_ctrl;
    wire wr_t1   = req.wr && req.addr == off_timing_one;
    wire wr_t2   = req.wr && req.addr == off_timing_two;
    wire wr_ana  = req.wr && req.addr == off_ana_switch;
    wire busy    = state != st_idle;
    wire powered = !analog_module_switch[ana_switch_adc];
    wire start_rise = wr_scan && req.wdata[start_bit] && !scan_control[start_bit]
                      && !busy && powered;
    wire [1:0] div_sel = converter_clock_control[1:0];
    wire [7:0] div_limit = (div_sel == 2'd0) ? div_code0 :
                           (div_sel == 2'd1) ? div_code1 :
                           (div_sel == 2'd2) ? div_code2 : div_code3;
    // Divider codes are half periods; a full tick period is twice (code + 1) reference clocks
    wire [7:0] div_top   = 8'({div_limit, 1'b1});
    wire [9:0] sample_len = 10'({2'b00, sample_time_setting} + 10'h001) * sample_mult;
    wire last_sample = sample_cnt == sample_len - 10'h001;
    wire [11:0] kept = comp_val ? trial : (trial & ~(12'h001 << bit_idx));

    // Converter clock divider, restarted at each scan
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
        begin
            div_cnt  <= 8'h00;
            adc_tick <= 1'b0;
        end
        else
        begin
            div_cnt  <= (start_rise || div_cnt >= div_top) ? 8'h00 : div_cnt + 8'h01;
            adc_tick <= !start_rise && div_cnt >= div_top;
        end

    // Comparator synchroniser; accepted once stages two and three agree
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
        begin
            comp_s1  <= 1'b0;
            comp_s2  <= 1'b0;
            comp_s3  <= 1'b0;
            comp_val <= 1'b0;
        end
        else
        begin
            comp_s1 <= comp_in;
            comp_s2 <= comp_s1;
            comp_s3 <= comp_s2;
            if (comp_s2 == comp_s3)
                comp_val <= comp_s3;
        end

    // Software registers
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
        begin
            sample_time_setting     <= rst_zero;
            converter_clock_control <= rst_zero;
            sampling_timing_one     <= rst_zero;
            sampling_timing_two     <= rst_timing_two;
            analog_module_switch    <= rst_ana_switch;
        end
        else
        begin
            if (wr_spt)
                sample_time_setting <= req.wdata;
            if (wr_clk)
                converter_clock_control <= {4'h0, req.wdata[3:0]};
            if (wr_t1)
                sampling_timing_one <= req.wdata;
            if (wr_t2)
                sampling_timing_two <= {1'b0, req.wdata[6:0]};
            if (wr_ana)
                analog_module_switch <= req.wdata;
        end

    // Pin function select registers
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_pin
            always_ff @(posedge ref_clk or posedge rst)
                if (rst)
                    pin_sel[g] <= rst_zero;
                else if (req.wr && req.addr == off_pin_sel_one + 8'(g))
                    pin_sel[g] <= req.wdata;
        end
    endgenerate

    // Scan control: channel locked while busy, start cleared by hardware
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
            scan_control <= rst_zero;
        else if (state == st_done)
            scan_control[start_bit] <= 1'b0;
        else if (wr_scan && !busy)
            scan_control <= {2'b00, req.wdata[chan_msb:chan_lsb], start_rise};

    // Sequencer: sample, then successive approximation, then publish
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
        begin
            state      <= st_idle;
            sample_cnt <= 10'h000;
            bit_idx    <= 4'h0;
            trial      <= 12'h000;
            result     <= 12'h000;
            conv_irq   <= 1'b0;
        end
        else
        begin
            conv_irq <= state == st_done;
            case (state)
                st_idle:
                    if (start_rise)
                    begin
                        state      <= st_sample;
                        sample_cnt <= 10'h000;
                    end
                st_sample:
                    if (adc_tick)
                    begin
                        sample_cnt <= sample_cnt + 10'h001;
                        if (last_sample)
                        begin
                            state   <= st_convert;
                            bit_idx <= 4'(result_bits - 1);
                            trial   <= 12'h800;
                        end
                    end
                st_convert:
                    if (adc_tick)
                    begin
                        if (bit_idx == 4'h0)
                        begin
                            result <= kept;
                            state  <= st_done;
                        end
                        else
                        begin
                            trial   <= kept | (12'h001 << (bit_idx - 4'h1));
                            bit_idx <= bit_idx - 4'h1;
                        end
                    end
                st_done:
                    state <= st_idle;
                default:
                    state <= st_idle;
            endcase
        end

    // Read data and analog drive, all registered
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
        begin
            rdata          <= 8'h00;
            ana            <= '0;
            adc_power_down <= 1'b1;
            timing_one_out <= rst_zero;
            timing_two_out <= rst_timing_two;
            pin_sel_out    <= 32'h0000_0000;
        end
        else
        begin
            ana.sample     <= state == st_sample;
            ana.chan       <= scan_control[chan_msb:chan_lsb];
            ana.dac        <= trial;
            adc_power_down <= !powered;
            timing_one_out <= sampling_timing_one;
            timing_two_out <= sampling_timing_two;
            pin_sel_out    <= {pin_sel[3], pin_sel[2], pin_sel[1], pin_sel[0]};
            case (req.addr)
                off_sample_time: rdata <= sample_time_setting;
                off_scan_ctrl:   rdata <= scan_control;
                off_clk_ctrl:    rdata <= converter_clock_control;
                off_result_hi:   rdata <= {4'h0, result[11:8]};
                off_result_lo:   rdata <= result[7:0];
                off_timing_one:  rdata <= sampling_timing_one;
                off_timing_two:  rdata <= sampling_timing_two;
                off_pin_sel_one: rdata <= pin_sel[0];
                off_pin_sel_two: rdata <= pin_sel[1];
                off_pin_sel_thr: rdata <= pin_sel[2];
                off_pin_sel_fou: rdata <= pin_sel[3];
                off_ana_switch:  rdata <= analog_module_switch;
                default:         rdata <= 8'h00;
            endcase
        end

endmodule // sas_sequencer

//--- bench/sas_sequencer_sva.sv
// Checker for the converter sequencer ports.
// Assumes it is bound to sas_sequencer from the bench top file.
module sas_sequencer_sva
    import sas_pkg::*;
(
    // Clock and reset
    input wire logic                 ref_clk,
    input wire logic                 rst,
    // Register port
    input wire sas_pkg::sas_req_type req,
    input wire logic [7:0]           rdata,
    // Analog side and flags
    input wire logic                 comp_in,
    input wire sas_pkg::sas_ana_type ana,
    input wire logic                 adc_power_down,
    input wire logic [7:0]           timing_one_out,
    input wire logic [7:0]           timing_two_out,
    input wire logic [31:0]          pin_sel_out,
    input wire logic                 conv_irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Sampling phase, then a search with no flag
    sequence s_sampling;
        ana.sample [*8];
    endsequence
    sequence s_search;
        (!ana.sample && !conv_irq) [*8];
    endsequence

    AST_SAMPLE_MIN: assert property ($rose(ana.sample) |-> s_sampling)
        else $error("sampling phase too short");
    AST_SEARCH: assert property ($fell(ana.sample) |-> s_search)
        else $error("search ended too early");
    AST_IRQ_PULSE: assert property (conv_irq |=> !conv_irq)
        else $error("interrupt request longer than one cycle");
    AST_IRQ_IDLE: assert property (conv_irq |-> !ana.sample)
        else $error("interrupt request while sampling");
    AST_CHAN_HELD: assert property (ana.sample && $past(ana.sample) |-> $stable(ana.chan))
        else $error("channel changed while sampling");
    AST_POWER_GATE: assert property (adc_power_down |-> !ana.sample)
        else $error("sampling while powered down");
    // Exported copies trail the register by one more flop
    AST_PIN_SEL: assert property (
        req.wr && req.addr == off_pin_sel_one |-> ##2 pin_sel_out[7:0] == $past(req.wdata, 2))
        else $error("pin select copy not updated");
    AST_TIMING_TWO: assert property (
        req.wr && req.addr == off_timing_two
        |-> ##2 timing_two_out == {1'b0, $past(req.wdata[6:0], 2)})
        else $error("timing two copy not updated");
endmodule // sas_sequencer_sva

//--- bench/sar_adc_sequencer_bench.sv
// Self-checking bench for the converter sequencer.
// Assumes the package, the sequencer and the checker are compiled first.
module sar_adc_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import sas_pkg::*;
    localparam logic [7:0] ra[13] = '{8'hb4, 8'hb5, 8'hb6, 8'hb9, 8'hba, 8'hbb, 8'hbc,
        8'hd9, 8'hda, 8'hdb, 8'hdc, 8'hfe, 8'h00};
    localparam logic [7:0] rv[13] = '{0, 0, 0, 0, 0, 0, 8'h02, 0, 0, 0, 0, 8'h1f, 0};
    localparam int dv[4] = '{int'(div_code0), int'(div_code1), int'(div_code2), int'(div_code3)};
    logic        ref_clk = 0;
    logic        rst = 1;
    sas_req_type req = '0;
    logic [7:0]  rdata;
    logic        comp_in = 0;
    sas_ana_type ana;
    logic        adc_power_down;
    logic [7:0]  timing_one_out;
    logic [7:0]  timing_two_out;
    logic [31:0] pin_sel_out;
    logic        conv_irq;
    int          fail_count = 0;
    int          checked = 0;
    int          seed = 32'h1ec0;
    int          irqs = 0;
    int          slen = 0;
    int          last_len = 0;
    logic        rd_due = 0;
    logic        rd_seen = 0;
    logic [11:0] vin = '0;
    logic [7:0]  rq[$];

    sas_sequencer dut (.ref_clk, .rst, .req, .rdata, .comp_in, .ana, .adc_power_down,
        .timing_one_out, .timing_two_out, .pin_sel_out, .conv_irq);

    // Clock
    always #2 ref_clk = ~ref_clk;

    // Comparator stand-in and sampling length meter
    always @(posedge ref_clk)
    begin
        comp_in <= (vin >= ana.dac);
        rd_seen <= rd_due;
        if (ana.sample)
            slen <= slen + 1;
        else if (slen != 0)
        begin
            last_len <= slen;
            slen <= 0;
        end
    end

    // Output watcher: read data against the oldest note
    always @(negedge ref_clk)
    begin
        if (rd_seen)
            check("rdata", rdata, rq.pop_front());
        if (conv_irq)
            irqs++;
    end

    task automatic check(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [7:0] a, d);
        @(posedge ref_clk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge ref_clk);
        req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, e);
        @(posedge ref_clk);
        req <= '{1'b0, 1'b1, a, 8'h00};
        rd_due <= 1'b1;
        rq.push_back(e);
        @(posedge ref_clk);
        rd_due <= 1'b0;
    endtask

    // One conversion with a random input, and a random channel except channel 26 for clock code 3
    task automatic convert(input logic [1:0] ck);
        logic [4:0] ch;
        logic [7:0] spt;
        int t;
        int n;
        ch = (ck == 3) ? 5'd26 : 5'($unsigned($random(seed)) % 26);
        spt = 8'($random(seed) & 3);
        vin = 12'($random(seed));
        t = 2 * (dv[ck] + 1);
        n = irqs;
        wr(8'hb6, {6'h00, ck});
        wr(8'hb4, spt);
        wr(8'hb5, {2'b00, ch, 1'b1});
        for (int i = 0; i < 20000 && irqs == n; i++)
            @(posedge ref_clk);
        check("irq", irqs, n + 1);
        check("chan", ana.chan, ch);
        check("sample", (last_len + t / 2) / t, (spt + 1) * 4);
        rd(8'hb9, {4'h0, vin[11:8]});
        rd(8'hba, vin[7:0]);
        rd(8'hb5, {2'b00, ch, 1'b0});
        $display("conversion with clock code %0d done", ck);
    endtask

    task automatic stop_test;
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        logic [7:0] d;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (ra[i])
            rd(ra[i], rv[i]);
        $display("reset values done");
        for (int i = 0; i < 4; i++)
        begin
            d = 8'($random(seed));
            wr(8'hd9 + 8'(i), d);
            rd(8'hd9 + 8'(i), d);
        end
        d = 8'($random(seed));
        wr(8'hbc, d);
        rd(8'hbc, d & 8'h7f);
        wr(8'hbb, d);
        rd(8'hbb, d);
        check("timing one", timing_one_out, d);
        check("power down", adc_power_down, 1'b1);
        wr(8'hb9, 8'hff);
        rd(8'hb9, 8'h00);
        wr(8'hb5, 8'h01);
        repeat (200) @(posedge ref_clk);
        check("gated", irqs, 0);
        wr(8'hb5, 8'h00);
        wr(8'hfe, 8'h00);
        repeat (2) @(posedge ref_clk);
        check("power up", adc_power_down, 1'b0);
        $display("register access done");
        for (int c = 0; c < 4; c++)
            convert(2'(c));
        stop_test();
    end

    // Watchdog sized well above the expected run
    initial
    begin
        #100000;
        fail_count++;
        stop_test();
    end
endmodule // sar_adc_sequencer_bench

bind sas_sequencer sas_sequencer_sva chk (.ref_clk, .rst, .req, .rdata, .comp_in, .ana,
    .adc_power_down, .timing_one_out, .timing_two_out, .pin_sel_out, .conv_irq);
